// *** rtl/dao_pkg.sv ***
// constants and carrier types for the dual converter output port
// Overview of operation
// - both channels take a new sample on every rising sample clock edge outside sleep and power-down
// - output words change after an edge and are valid at the next edge
// - each output word belongs to the sample taken five cycles earlier
// - two independent 10-bit words, channel a and b, updated together
// - format select low gives offset binary, high gives two's complement
// - offset binary zero is 10 0000 0000; two's complement inverts the msb
// - sleep disables both conversion channels, only reference bias stays on
// - power-down high shuts down all conversion activity
// - power-down with output enable low holds the last output words
// - output enable high floats all data drivers, low drives them
// - reference input tied to ground switches the reference buffers off
package dao_pkg;
  localparam int unsigned DAO_WORD_W      = 10;
  localparam int unsigned DAO_LATENCY     = 5;
  localparam int unsigned DAO_FIFO_DEPTH  = 4;
  localparam int unsigned DAO_PAIR_W      = 2 * DAO_WORD_W;
  localparam logic [9:0]  DAO_WORD_RESET  = 10'h200;
  localparam int unsigned DAO_MSB_POS     = DAO_WORD_W - 1;
  localparam logic [2:0]  DAO_FILL_RESET  = 3'h0;

  typedef struct packed {
    logic [DAO_WORD_W-1:0] chan_a;
    logic [DAO_WORD_W-1:0] chan_b;
  } dao_pair_t;

  typedef struct packed {
    logic sleep;
    logic full_powerdown_request;
    logic reference_level_grounded;
  } dao_power_t;

  typedef enum logic [2:0] {
    DAO_ST_RUN   = 3'b001,
    DAO_ST_SLEEP = 3'b010,
    DAO_ST_DOWN  = 3'b100
  } dao_state_t;
endpackage

// *** rtl/dao_fifo.sv ***
// small valid/ready fifo for sample pairs
`timescale 1ns/1ps
module dao_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW-1:0]    rd_ptr_nxt;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
    end
    if (push && !pop) begin
      count_nxt = count_r + (AW+1)'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

  // storage has no reset; only written entries are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  a_fifo_no_overflow : assert property (@(posedge ref_clk) disable iff (!reset_n)
    count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// *** rtl/dao_output_port.sv ***
// dual channel sample output port: pipeline, coding, power modes, drivers
`timescale 1ns/1ps
module dao_output_port #(
  parameter int unsigned WORD_W  = dao_pkg::DAO_WORD_W,
  parameter int unsigned LATENCY = dao_pkg::DAO_LATENCY
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // quantised samples from both converter cores
  input  wire logic [WORD_W-1:0] core_a_code,
  input  wire logic [WORD_W-1:0] core_b_code,
  // control pins
  input  wire logic              format_twos_comp,
  input  wire logic              output_enable_n,
  input  wire dao_pkg::dao_power_t power_ctrl,
  // downstream stream tap
  output logic                   stream_valid,
  input  wire logic              stream_ready,
  output dao_pkg::dao_pair_t     stream_pair,
  output logic                   sample_dropped,
  // status
  output logic                   converters_enabled,
  output logic                   reference_buffers_on,
  output logic                   words_fresh,
  // data pins
  output logic [WORD_W-1:0]      channel_a_sample_word,
  output logic [WORD_W-1:0]      channel_a_sample_word_oe,
  output logic [WORD_W-1:0]      channel_b_sample_word,
  output logic [WORD_W-1:0]      channel_b_sample_word_oe
);
  dao_pkg::dao_state_t   state_r;
  dao_pkg::dao_state_t   state_nxt;
  logic [WORD_W-1:0]     pipe_a_r [LATENCY-1];
  logic [WORD_W-1:0]     pipe_a_nxt [LATENCY-1];
  logic [WORD_W-1:0]     pipe_b_r [LATENCY-1];
  logic [WORD_W-1:0]     pipe_b_nxt [LATENCY-1];
  logic [WORD_W-1:0]     out_a_r;
  logic [WORD_W-1:0]     out_a_nxt;
  logic [WORD_W-1:0]     out_b_r;
  logic [WORD_W-1:0]     out_b_nxt;
  logic [2:0]            fill_r;
  logic [2:0]            fill_nxt;
  logic                  running;
  logic                  fifo_in_ready;
  logic                  dropped_r;
  logic                  dropped_nxt;
  dao_pkg::dao_pair_t    fifo_in;

  // mode selection: power-down outranks sleep
  always_comb begin
    if (power_ctrl.full_powerdown_request) begin
      state_nxt = dao_pkg::DAO_ST_DOWN;
    end else if (power_ctrl.sleep) begin
      state_nxt = dao_pkg::DAO_ST_SLEEP;
    end else begin
      state_nxt = dao_pkg::DAO_ST_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= dao_pkg::DAO_ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    case (state_r)
      dao_pkg::DAO_ST_RUN:   running = 1'b1;
      dao_pkg::DAO_ST_SLEEP: running = 1'b0;
      dao_pkg::DAO_ST_DOWN:  running = 1'b0;
      default:               running = 1'b0;
    endcase
  end

  assign converters_enabled   = running;
  // bias stays alive in sleep; reference off in power-down or when grounded
  assign reference_buffers_on = !power_ctrl.reference_level_grounded
                                && (state_r != dao_pkg::DAO_ST_DOWN);

  // pipeline: edge 1 samples, stages shift, output latch at edge 5
  always_comb begin
    for (int i = 0; i < LATENCY-1; i++) begin
      pipe_a_nxt[i] = pipe_a_r[i];
      pipe_b_nxt[i] = pipe_b_r[i];
    end
    out_a_nxt = out_a_r;
    out_b_nxt = out_b_r;
    fill_nxt  = fill_r;
    if (running) begin
      pipe_a_nxt[0] = core_a_code;
      pipe_b_nxt[0] = core_b_code;
      for (int i = 1; i < LATENCY-1; i++) begin
        pipe_a_nxt[i] = pipe_a_r[i-1];
        pipe_b_nxt[i] = pipe_b_r[i-1];
      end
      // msb inversion turns offset binary into two's complement
      out_a_nxt = pipe_a_r[LATENCY-2]
                  ^ {format_twos_comp, {(WORD_W-1){1'b0}}};
      out_b_nxt = pipe_b_r[LATENCY-2]
                  ^ {format_twos_comp, {(WORD_W-1){1'b0}}};
      if (fill_r != 3'(LATENCY)) begin
        fill_nxt = fill_r + 3'h1;
      end
    end else begin
      // words hold at last value; pipeline must refill on wake
      fill_nxt = dao_pkg::DAO_FILL_RESET;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < LATENCY-1; i++) begin
        pipe_a_r[i] <= dao_pkg::DAO_WORD_RESET;
        pipe_b_r[i] <= dao_pkg::DAO_WORD_RESET;
      end
      out_a_r <= dao_pkg::DAO_WORD_RESET;
      out_b_r <= dao_pkg::DAO_WORD_RESET;
      fill_r  <= dao_pkg::DAO_FILL_RESET;
    end else begin
      for (int i = 0; i < LATENCY-1; i++) begin
        pipe_a_r[i] <= pipe_a_nxt[i];
        pipe_b_r[i] <= pipe_b_nxt[i];
      end
      out_a_r <= out_a_nxt;
      out_b_r <= out_b_nxt;
      fill_r  <= fill_nxt;
    end
  end

  assign words_fresh = (fill_r == 3'(LATENCY));

  // drivers: enable follows the pin, value comes straight from the latch
  assign channel_a_sample_word    = out_a_r;
  assign channel_b_sample_word    = out_b_r;
  assign channel_a_sample_word_oe = {WORD_W{!output_enable_n}};
  assign channel_b_sample_word_oe = {WORD_W{!output_enable_n}};

  // stream tap: fresh words only; a full fifo drops rather than stalls the
  // converter, because sampling cannot pause
  assign fifo_in.chan_a = out_a_r;
  assign fifo_in.chan_b = out_b_r;
  // only a pair actually offered to a full fifo counts as dropped
  assign dropped_nxt    = words_fresh && running && !fifo_in_ready;
  assign sample_dropped = dropped_r;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dropped_r <= 1'b0;
    end else begin
      dropped_r <= dropped_nxt;
    end
  end

  dao_fifo #(
    .WIDTH (dao_pkg::DAO_PAIR_W),
    .DEPTH (dao_pkg::DAO_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (words_fresh && running),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_pair)
  );

  sequence s_sample_taken;
    running ##0 $stable(running)[*1];
  endsequence

  // five running edges load, shift and latch; the word is checked one edge later
  a_latency_five : assert property (@(posedge ref_clk) disable iff (!reset_n)
    running [*5] ##1 1'b1 |-> out_a_r == ($past(core_a_code, 5)
      ^ {format_twos_comp, {(WORD_W-1){1'b0}}}) || $changed(format_twos_comp))
    else $error("channel a word does not match sample five cycles back");
  a_chan_b_latency : assert property (@(posedge ref_clk) disable iff (!reset_n)
    ($past(running) && $past(running, 2) && $past(running, 3) && $past(running, 4)
      && $past(running, 5) && $past(reset_n, 5) && $stable(format_twos_comp))
    |-> out_b_r[WORD_W-2:0] == $past(core_b_code[WORD_W-2:0], 5))
    else $error("channel b word latency wrong");
  a_sample_edge : assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_sample_taken |=> pipe_a_r[0] == $past(core_a_code))
    else $error("first stage missed the sample");
  a_hold_down : assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == dao_pkg::DAO_ST_DOWN && !output_enable_n) |=>
      $stable(channel_a_sample_word) && $stable(channel_b_sample_word))
    else $error("words moved during power-down");
  a_sleep_off : assert property (@(posedge ref_clk) disable iff (!reset_n)
    (power_ctrl.sleep && !power_ctrl.full_powerdown_request) |=>
      !converters_enabled && (reference_buffers_on
        == !power_ctrl.reference_level_grounded))
    else $error("sleep did not stop the converters");
  a_down_off : assert property (@(posedge ref_clk) disable iff (!reset_n)
    power_ctrl.full_powerdown_request |=> !converters_enabled && !reference_buffers_on)
    else $error("power-down left activity on");
  a_float_pins : assert property (@(posedge ref_clk) disable iff (!reset_n)
    output_enable_n == (channel_a_sample_word_oe == '0)
      && channel_a_sample_word_oe == channel_b_sample_word_oe)
    else $error("driver enable disagrees with output enable");
  a_ref_ground : assert property (@(posedge ref_clk) disable iff (!reset_n)
    power_ctrl.reference_level_grounded |-> !reference_buffers_on)
    else $error("reference buffers on with grounded input");
  a_format_msb : assert property (@(posedge ref_clk) disable iff (!reset_n)
    (running && $past(running) && $changed(format_twos_comp)
      && $stable(pipe_a_r[LATENCY-2]))
    |=> out_a_r[WORD_W-2:0] == $past(pipe_a_r[LATENCY-2][WORD_W-2:0]))
    else $error("format select altered low bits");
  a_refill_gate : assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(running) |-> !words_fresh ##1 !words_fresh [*4])
    else $error("words marked fresh before refill");
  a_change_after_edge : assert property (@(posedge ref_clk) disable iff (!reset_n)
    !running |=> $stable(out_a_r) && $stable(out_b_r))
    else $error("output changed without a clock of conversion");
endmodule

// *** tb/dao_sink.sv ***
// downstream capture model for the paired sample stream
`timescale 1ns/1ps
module dao_sink (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // stream from the port
  input  wire logic               stream_valid,
  output logic                    stream_ready,
  input  wire dao_pkg::dao_pair_t stream_pair,
  // bench control and observation
  input  wire logic               stall,
  output dao_pkg::dao_pair_t      last_pair,
  output int                      n_taken
);
  // ready only moves just after an edge, like a registered receiver
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stream_ready <= 1'b0;
      last_pair    <= '0;
      n_taken      <= 0;
    end else begin
      stream_ready <= !stall;
      // the stream only carries refilled words, so stale ones never arrive here
      if (stream_valid && stream_ready) begin
        last_pair <= stream_pair;
        n_taken   <= n_taken + 1;
      end
    end
  end
endmodule

// *** tb/dual_adc_output_port_tb.sv ***
// bench for the dual converter output port
`timescale 1ns/1ps
module dual_adc_output_port_tb;
  logic               ref_clk, reset_n, fmt, oe_n, stall, sv, sr, drop, cen, ref_on, fresh;
  logic [9:0]         ca, cb, wa, wa_oe, wb, wb_oe;
  dao_pkg::dao_power_t pwr;
  dao_pkg::dao_pair_t pair, last;
  int                 n_taken, n_fail, checks, n0;

  dao_output_port dut (.ref_clk(ref_clk), .reset_n(reset_n), .core_a_code(ca),
    .core_b_code(cb), .format_twos_comp(fmt), .output_enable_n(oe_n), .power_ctrl(pwr),
    .stream_valid(sv), .stream_ready(sr), .stream_pair(pair), .sample_dropped(drop),
    .converters_enabled(cen), .reference_buffers_on(ref_on), .words_fresh(fresh),
    .channel_a_sample_word(wa), .channel_a_sample_word_oe(wa_oe),
    .channel_b_sample_word(wb), .channel_b_sample_word_oe(wb_oe));
  dao_sink sink (.ref_clk(ref_clk), .reset_n(reset_n), .stream_valid(sv),
    .stream_ready(sr), .stream_pair(pair), .stall(stall), .last_pair(last),
    .n_taken(n_taken));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk_v(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: flag %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // a fresh code every cycle; each word must trail its sample by five edges
  task automatic t_latency();
    logic [9:0] h [$];
    for (int i = 0; i < 14; i++) begin
      @(negedge ref_clk);
      if (i >= 5) chk_v({wa, wb}, {h[i-5], ~h[i-5]});
      h.push_back(10'(i * 83));
      ca = h[i];
      cb = ~h[i];
    end
    $display("test latency done");
  endtask
  task automatic t_format();
    logic [9:0] t [3] = '{10'h000, 10'h200, 10'h3FF};
    for (int f = 0; f < 2; f++)
      for (int k = 0; k < 3; k++) begin
        fmt = f[0];
        ca = t[k];
        cb = ~t[k];
        cyc(6);
        chk_v({wa, wb}, {t[k] ^ {f[0], 9'h000}, ~t[k] ^ {f[0], 9'h000}});
      end
    fmt = 1'b0;
    $display("test format done");
  endtask
  task automatic t_oe();
    oe_n = 1'b1;
    cyc(1);
    chk_v({wa_oe, wb_oe}, 20'h00000);
    oe_n = 1'b0;
    cyc(1);
    chk_v({wa_oe, wb_oe}, 20'hFFFFF);
    $display("test enable done");
  endtask
  // mode 0 sleeps, mode 1 powers down; words must freeze, then refill on wake
  task automatic t_power(input logic mode);
    ca = 10'h155;
    cb = 10'h2AA;
    cyc(6);
    pwr.sleep = !mode;
    pwr.full_powerdown_request = mode;
    cyc(1);
    ca = 10'h0F0;
    cyc(7);
    chk_v({wa, wb}, {10'h155, 10'h2AA});
    chk_b(cen, 1'b0);
    chk_b(ref_on, !mode);
    pwr.sleep = 1'b0;
    pwr.full_powerdown_request = 1'b0;
    cyc(2);
    chk_b(fresh, 1'b0);
    cyc(6);
    chk_b(fresh, 1'b1);
    chk_v({wa, wb}, {10'h0F0, 10'h2AA});
    $display("test power mode %0d done", mode);
  endtask
  task automatic t_refgnd();
    pwr.reference_level_grounded = 1'b1;
    cyc(1);
    chk_b(ref_on, 1'b0);
    chk_b(cen, 1'b1);
    pwr.reference_level_grounded = 1'b0;
    cyc(1);
    chk_b(ref_on, 1'b1);
    $display("test reference done");
  endtask
  // stall the sink until the buffer overflows, stop pushes, drain four pairs
  task automatic t_fifo();
    stall = 1'b1;
    cyc(10);
    chk_b(sv, 1'b1);
    chk_b(drop, 1'b1);
    pwr.sleep = 1'b1;
    cyc(3);
    chk_b(drop, 1'b0);
    n0 = n_taken;
    stall = 1'b0;
    cyc(8);
    chk_v(20'(n_taken - n0), 20'h00004);
    chk_b(sv, 1'b0);
    chk_v(last, {10'h0F0, 10'h2AA});
    pwr.sleep = 1'b0;
    cyc(8);
    $display("test buffer done");
  endtask

  initial begin
    reset_n = 1'b0;
    fmt = 1'b0;
    oe_n = 1'b0;
    stall = 1'b0;
    ca = 10'h000;
    cb = 10'h000;
    pwr = '0;
    n_fail = 0;
    checks = 0;
    cyc(6);
    chk_v({wa, wb}, {10'h200, 10'h200});
    reset_n = 1'b1;
    cyc(1);
    t_latency();
    t_format();
    t_oe();
    t_power(1'b0);
    t_power(1'b1);
    t_refgnd();
    t_fifo();
    stop_test();
  end

  // the sequence needs about 135 cycles
  initial begin
    #(40 * 2000);
    n_fail++;
    stop_test();
  end
endmodule
